// ### src/sesw_device.sv
// Purpose: two-wire slave front end of a 256 x 8 nonvolatile memory
// Assumes: bus pins arrive asynchronously and are synchronised here
// Notes: 8-byte page, buffered and committed at the end of the write cycle
`timescale 1ns/1ps
`default_nettype none
module sesw_device #(
	parameter int unsigned P_WRITE_CYCLES = sesw_pkg::WRITE_CYCLES
) (
	sesw_if.device bus,
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [2:0] i_device_select_pins,
	input wire logic i_write_protect_pin,
	output logic o_busy
);
	logic [sesw_pkg::SYNC_W-1:0] pin_s1_q;
	logic [sesw_pkg::SYNC_W-1:0] pin_s2_q;
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl;
	logic sda;
	logic wp;
	logic [2:0] sel;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	sesw_pkg::sesw_dev_state_t state_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [sesw_pkg::ADDR_W-1:0] addr_q;
	logic oe_n_q;
	logic mack_q;
	logic sda_q;
	logic busy_q;
	logic [sesw_pkg::WCNT_W-1:0] wcnt_q;
	logic [sesw_pkg::PAGE_BYTES-1:0] valid_q;
	logic [sesw_pkg::DATA_W-1:0] page_buf [sesw_pkg::PAGE_BYTES];
	logic [sesw_pkg::DATA_W-1:0] mem [sesw_pkg::MEM_DEPTH];
	logic [sesw_pkg::DATA_W-1:0] mem_rd;
	logic dev_hit;
	logic byte_in;
	logic wr_done;
	logic commit_start;

	// the first stage feeds only the second, to settle metastability
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_s1_q <= 6'h3f;
			pin_s2_q <= 6'h3f;
		end else begin
			pin_s1_q <= {bus.scl, bus.sda, i_write_protect_pin, i_device_select_pins};
			pin_s2_q <= pin_s1_q;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl;
			sda_prev_q <= sda;
		end
	end

	assign scl = pin_s2_q[5];
	assign sda = pin_s2_q[4];
	assign wp = pin_s2_q[3];
	assign sel = pin_s2_q[2:0];
	assign scl_rise = scl && !scl_prev_q;
	assign scl_fall = !scl && scl_prev_q;
	// data edges only count as conditions while scl stays high
	assign start_det = scl && scl_prev_q && sda_prev_q && !sda;
	assign stop_det = scl && scl_prev_q && !sda_prev_q && sda;
	assign dev_hit = (shift_q[7:4] == sesw_pkg::DEV_TYPE) && (shift_q[3:1] == sel);
	assign mem_rd = mem[addr_q];
	assign byte_in = scl_fall && (bit_cnt_q == sesw_pkg::BIT_ACK) && (state_q == sesw_pkg::ST_WDATA);
	assign wr_done = (state_q == sesw_pkg::ST_BUSY) && (wcnt_q == sesw_pkg::WCNT_W'(P_WRITE_CYCLES - 1));
	// protected or empty writes end quietly so the next transfer is served
	assign commit_start = (state_q == sesw_pkg::ST_WDATA) && (|valid_q) && !wp;

	// protocol engine; reacts to the master's edges, except that busy ends on the write timer
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= sesw_pkg::ST_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			addr_q <= 8'h00;
			oe_n_q <= 1'b1;
			mack_q <= 1'b0;
		end else if (state_q == sesw_pkg::ST_BUSY) begin
			// inputs ignored, so polls see no acknowledge
			oe_n_q <= 1'b1;
			if (wr_done) begin
				state_q <= sesw_pkg::ST_IDLE;
			end
		end else if (stop_det) begin
			oe_n_q <= 1'b1;
			state_q <= commit_start ? sesw_pkg::ST_BUSY : sesw_pkg::ST_IDLE;
		end else if (start_det) begin
			state_q <= sesw_pkg::ST_DEV;
			bit_cnt_q <= 4'h0;
			oe_n_q <= 1'b1;
		end else if (state_q != sesw_pkg::ST_IDLE) begin
			if (scl_rise) begin
				// sample in the high half, where the line is stable
				if (bit_cnt_q < sesw_pkg::BIT_ACK) begin
					shift_q <= {shift_q[6:0], sda};
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end else if (bit_cnt_q == sesw_pkg::BIT_ACK && state_q == sesw_pkg::ST_RDATA) begin
					mack_q <= !sda;
					bit_cnt_q <= sesw_pkg::BIT_POST;
				end
			end else if (scl_fall) begin
				if (state_q == sesw_pkg::ST_RDATA) begin
					if (bit_cnt_q == sesw_pkg::BIT_POST) begin
						if (mack_q) begin
							oe_n_q <= mem_rd[7];
							tx_q <= {mem_rd[6:0], 1'b0};
							addr_q <= addr_q + 8'h01;
							bit_cnt_q <= 4'h0;
						end else begin
							oe_n_q <= 1'b1;
							state_q <= sesw_pkg::ST_IDLE;
						end
					end else if (bit_cnt_q == sesw_pkg::BIT_ACK) begin
						oe_n_q <= 1'b1;
					end else begin
						oe_n_q <= tx_q[7];
						tx_q <= {tx_q[6:0], 1'b0};
					end
				end else if (bit_cnt_q == sesw_pkg::BIT_ACK) begin
					bit_cnt_q <= sesw_pkg::BIT_POST;
					case (state_q)
						sesw_pkg::ST_DEV: begin
							if (dev_hit) begin
								oe_n_q <= 1'b0;
								mack_q <= 1'b1;
								state_q <= shift_q[0] ? sesw_pkg::ST_RDATA : sesw_pkg::ST_WADDR;
							end else begin
								state_q <= sesw_pkg::ST_IDLE;
							end
						end
						sesw_pkg::ST_WADDR: begin
							oe_n_q <= 1'b0;
							addr_q <= shift_q;
							state_q <= sesw_pkg::ST_WDATA;
						end
						sesw_pkg::ST_WDATA: begin
							// acknowledge at once, step only inside the page
							oe_n_q <= 1'b0;
							addr_q <= {addr_q[7:3], addr_q[2:0] + 3'h1};
						end
						default: begin
							state_q <= sesw_pkg::ST_IDLE;
						end
					endcase
				end else if (bit_cnt_q == sesw_pkg::BIT_POST) begin
					oe_n_q <= 1'b1;
					bit_cnt_q <= 4'h0;
				end
			end
		end
	end

	// page buffer marks; a rewrite of a slot replaces the older byte
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			valid_q <= 8'h00;
		end else if (state_q == sesw_pkg::ST_IDLE || wr_done) begin
			valid_q <= 8'h00;
		end else if (start_det && state_q != sesw_pkg::ST_BUSY) begin
			valid_q <= 8'h00;
		end else if (byte_in) begin
			valid_q[addr_q[2:0]] <= 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (byte_in) begin
			page_buf[addr_q[2:0]] <= shift_q;
		end
	end

	// array is not reset: contents stand for nonvolatile storage
	always_ff @(posedge i_core_clk) begin
		if (wr_done) begin
			for (int i = 0; i < sesw_pkg::PAGE_BYTES; i++) begin
				if (valid_q[i]) begin
					mem[{addr_q[7:3], sesw_pkg::PAGE_W'(i)}] <= page_buf[i];
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wcnt_q <= 20'h0_0000;
			busy_q <= 1'b0;
		end else begin
			busy_q <= (state_q == sesw_pkg::ST_BUSY) && !wr_done;
			if (state_q != sesw_pkg::ST_BUSY || wr_done) begin
				wcnt_q <= 20'h0_0000;
			end else begin
				wcnt_q <= wcnt_q + 20'h0_0001;
			end
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sda_q <= 1'b0;
		end else begin
			sda_q <= 1'b0;
		end
	end

	assign bus.dev_sda = sda_q;
	assign bus.dev_sda_oe_n = oe_n_q;
	assign o_busy = busy_q;
endmodule
`default_nettype wire

// ### src/sesw_if.sv
// Purpose: two-wire bus between master and memory slave
// Assumes: clock line driven by the master only
// Notes: data line is wired-and of both open-drain drivers
`timescale 1ns/1ps
`default_nettype none
interface sesw_if;
	logic scl;
	logic sda;
	logic mst_sda;
	logic mst_sda_oe_n;
	logic dev_sda;
	logic dev_sda_oe_n;
	// line sits high unless an enabled driver pulls it low
	assign sda = !((!mst_sda_oe_n && !mst_sda) || (!dev_sda_oe_n && !dev_sda));
	modport device(input scl, input sda, output dev_sda, output dev_sda_oe_n);
	modport master(output scl, input sda, output mst_sda, output mst_sda_oe_n);
endinterface
`default_nettype wire

// ### src/sesw_master.sv
// Purpose: byte-level two-wire bus master for the memory slave
// Assumes: one command per byte, optional start before and stop after
// Notes: serial clock made by dividing the core clock
`timescale 1ns/1ps
`default_nettype none
module sesw_master #(
	parameter int unsigned P_QTR_CYCLES = sesw_pkg::QTR_CYCLES
) (
	sesw_if.master bus,
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_cmd_valid,
	input wire logic i_cmd_start,
	input wire logic i_cmd_stop,
	input wire logic i_cmd_read,
	input wire logic i_cmd_ack,
	input wire logic [7:0] i_cmd_byte,
	output logic o_cmd_ready,
	output logic o_done,
	output logic [7:0] o_rdata,
	output logic o_ack_seen
);
	sesw_pkg::sesw_mst_state_t state_q;
	logic [sesw_pkg::QTR_W-1:0] qtr_q;
	logic tick;
	logic [1:0] phase_q;
	logic [3:0] bit_q;
	logic [7:0] byte_q;
	logic stop_q;
	logic read_q;
	logic ack_q;
	logic scl_q;
	logic oe_n_q;
	logic sda_q;
	logic sda_s1_q;
	logic sda_s2_q;
	logic ready_q;
	logic done_q;
	logic [7:0] rdata_q;
	logic ack_seen_q;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_q <= 1'b0;
		end else begin
			sda_s1_q <= bus.sda;
			sda_s2_q <= sda_s1_q;
			sda_q <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			qtr_q <= 8'h00;
		end else if (state_q == sesw_pkg::M_IDLE || tick) begin
			qtr_q <= 8'h00;
		end else begin
			qtr_q <= qtr_q + 8'h01;
		end
	end
	assign tick = (qtr_q == sesw_pkg::QTR_W'(P_QTR_CYCLES - 1));

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= sesw_pkg::M_IDLE;
			phase_q <= 2'h0;
			bit_q <= 4'h0;
			byte_q <= 8'h00;
			stop_q <= 1'b0;
			read_q <= 1'b0;
			ack_q <= 1'b0;
			scl_q <= 1'b1;
			oe_n_q <= 1'b1;
			ready_q <= 1'b1;
			done_q <= 1'b0;
			rdata_q <= 8'h00;
			ack_seen_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				sesw_pkg::M_IDLE: begin
					if (i_cmd_valid && ready_q) begin
						ready_q <= 1'b0;
						byte_q <= i_cmd_byte;
						stop_q <= i_cmd_stop;
						read_q <= i_cmd_read;
						ack_q <= i_cmd_ack;
						phase_q <= 2'h0;
						bit_q <= 4'h0;
						state_q <= i_cmd_start ? sesw_pkg::M_START : sesw_pkg::M_BITS;
					end
				end
				sesw_pkg::M_START: begin
					if (tick) begin
						phase_q <= phase_q + 2'h1;
						case (phase_q)
							2'h0: oe_n_q <= 1'b1;
							2'h1: scl_q <= 1'b1;
							2'h2: oe_n_q <= 1'b0;
							default: begin
								scl_q <= 1'b0;
								state_q <= sesw_pkg::M_BITS;
							end
						endcase
					end
				end
				sesw_pkg::M_BITS: begin
					if (tick) begin
						phase_q <= phase_q + 2'h1;
						case (phase_q)
							2'h0: begin
								// change data only while the clock is low
								if (bit_q == sesw_pkg::BIT_ACK) begin
									oe_n_q <= read_q ? !ack_q : 1'b1;
								end else begin
									oe_n_q <= read_q ? 1'b1 : byte_q[7];
								end
							end
							2'h1: scl_q <= 1'b1;
							2'h2: begin
								if (bit_q == sesw_pkg::BIT_ACK) begin
									ack_seen_q <= !sda_s2_q;
								end else begin
									byte_q <= {byte_q[6:0], sda_s2_q};
								end
							end
							default: begin
								scl_q <= 1'b0;
								if (bit_q == sesw_pkg::BIT_ACK) begin
									rdata_q <= byte_q;
									if (stop_q) begin
										state_q <= sesw_pkg::M_STOP;
									end else begin
										done_q <= 1'b1;
										ready_q <= 1'b1;
										state_q <= sesw_pkg::M_IDLE;
									end
								end else begin
									bit_q <= bit_q + 4'h1;
								end
							end
						endcase
					end
				end
				default: begin
					if (tick) begin
						phase_q <= phase_q + 2'h1;
						case (phase_q)
							2'h0: oe_n_q <= 1'b0;
							2'h1: scl_q <= 1'b1;
							2'h2: oe_n_q <= 1'b1;
							default: begin
								done_q <= 1'b1;
								ready_q <= 1'b1;
								state_q <= sesw_pkg::M_IDLE;
							end
						endcase
					end
				end
			endcase
		end
	end

	assign bus.scl = scl_q;
	assign bus.mst_sda = sda_q;
	assign bus.mst_sda_oe_n = oe_n_q;
	assign o_cmd_ready = ready_q;
	assign o_done = done_q;
	assign o_rdata = rdata_q;
	assign o_ack_seen = ack_seen_q;
endmodule
`default_nettype wire

// ### src/sesw_pkg.sv
// Purpose: shared constants and types for the two-wire memory slave and its bus master
// Assumes: 100 MHz core clock on both ends
// Notes: device type code below is arbitrary
package sesw_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned SCL_HZ = 100_000;
	// quarter of a serial clock period, in core cycles
	localparam int unsigned QTR_CYCLES = CLK_HZ / (SCL_HZ * 4);
	localparam int QTR_W = 8;
	// self-timed write cycle, longest time in ms and its cycle count
	localparam int unsigned T_WRITE_MS = 10;
	localparam int unsigned WRITE_CYCLES = T_WRITE_MS * (CLK_HZ / 1000);
	localparam int WCNT_W = 20;
	// device type identifier, arbitrary value
	localparam logic [3:0] DEV_TYPE = 4'h5;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 256;
	localparam int PAGE_BYTES = 8;
	localparam int PAGE_W = 3;
	localparam int SYNC_W = 6;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_POST = 4'h9;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEV = 3'b001,
		ST_WADDR = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100,
		ST_BUSY = 3'b101
	} sesw_dev_state_t;
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_START = 2'b01,
		M_BITS = 2'b10,
		M_STOP = 2'b11
	} sesw_mst_state_t;
endpackage

// ### test/sesw_sva.sv
// Purpose: protocol checks on the two-wire link between master and memory slave
// Assumes: one core clock domain, async active-low reset
// Notes: device lags the bus by a few core cycles after synchronising
`timescale 1ns/1ps
`default_nettype none
module sesw_sva_chk #(
	parameter int unsigned P_WRITE_CYCLES = 200
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic scl,
	input wire logic sda,
	input wire logic mst_sda_oe_n,
	input wire logic dev_sda,
	input wire logic dev_sda_oe_n,
	input wire logic o_busy,
	input wire logic i_write_protect_pin
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);
	// length of the current busy run
	logic [31:0] busy_cnt_q;
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			busy_cnt_q <= 32'h0000_0000;
		end else if (o_busy) begin
			busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
		end else begin
			busy_cnt_q <= 32'h0000_0000;
		end
	end
	chk_busy_no_ack: assert property (o_busy |-> dev_sda_oe_n)
		else $error("device drives data line while busy");
	chk_dev_after_fall: assert property ($changed(dev_sda_oe_n) |-> !scl && $past(scl, 8))
		else $error("device data changed away from a clock fall");
	chk_dev_open_drain: assert property (!dev_sda_oe_n |-> !dev_sda)
		else $error("device drives a high level");
	chk_ack_held_high: assert property (!dev_sda_oe_n && $rose(scl) |-> (!sda)[*8])
		else $error("data line moved while clock high");
	chk_busy_after_stop: assert property ($rose(o_busy) |-> scl && sda && !i_write_protect_pin)
		else $error("busy started away from an idle bus or while protected");
	chk_busy_run_length: assert property ($fell(o_busy) |->
		busy_cnt_q + 2 >= P_WRITE_CYCLES && busy_cnt_q <= P_WRITE_CYCLES + 2)
		else $error("write cycle length wrong");
	chk_stop_releases: assert property ($rose(sda) && scl |-> (mst_sda_oe_n && dev_sda_oe_n)[*8])
		else $error("line pulled after stop");
	chk_start_not_dev: assert property ($fell(sda) && scl |-> dev_sda_oe_n)
		else $error("device made a start");
endmodule
`default_nettype wire

// ### test/tb_serial_eeprom_slave_write.sv
// Purpose: end-to-end bench, master writing and reading the memory slave
// Assumes: short write cycle parameter to keep the run brief
// Notes: short serial clock quarter keeps each byte near three hundred core cycles
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_slave_write;
	localparam int unsigned P_WR = 5000;
	// quarter of eight leaves room for the device's sync latency
	localparam int unsigned P_QTR = 8;
	localparam logic [2:0] SEL = 3'h5;
	localparam logic [7:0] ADDR_W = {sesw_pkg::DEV_TYPE, SEL, 1'b0};
	localparam logic [7:0] ADDR_R = {sesw_pkg::DEV_TYPE, SEL, 1'b1};
	logic i_core_clk;
	logic i_resetn;
	logic cmd_valid;
	logic cmd_start;
	logic cmd_stop;
	logic cmd_read;
	logic cmd_ack;
	logic [7:0] cmd_byte;
	logic wp;
	logic o_cmd_ready;
	logic o_done;
	logic [7:0] o_rdata;
	logic o_ack_seen;
	logic o_busy;
	logic [7:0] row_byte [3];
	logic row_ack [3];
	int mismatches;
	int n_compared;
	sesw_if bus();
	sesw_device #(.P_WRITE_CYCLES(P_WR)) u_sesw_device (.bus(bus), .i_core_clk(i_core_clk),
		.i_resetn(i_resetn), .i_device_select_pins(SEL), .i_write_protect_pin(wp), .o_busy(o_busy));
	sesw_master #(.P_QTR_CYCLES(P_QTR)) u_sesw_master (.bus(bus), .i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_cmd_valid(cmd_valid), .i_cmd_start(cmd_start), .i_cmd_stop(cmd_stop), .i_cmd_read(cmd_read),
		.i_cmd_ack(cmd_ack), .i_cmd_byte(cmd_byte), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
		.o_rdata(o_rdata), .o_ack_seen(o_ack_seen));
	sesw_sva_chk #(.P_WRITE_CYCLES(P_WR)) u_sesw_sva_chk (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.scl(bus.scl), .sda(bus.sda), .mst_sda_oe_n(bus.mst_sda_oe_n), .dev_sda(bus.dev_sda),
		.dev_sda_oe_n(bus.dev_sda_oe_n), .o_busy(o_busy), .i_write_protect_pin(wp));
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one byte command; ready is high because the previous one has finished
	task automatic do_cmd(input logic st, input logic sp, input logic rd, input logic ak, input logic [7:0] b);
		int n;
		@(posedge i_core_clk);
		cmd_valid <= 1'b1;
		cmd_start <= st;
		cmd_stop <= sp;
		cmd_read <= rd;
		cmd_ack <= ak;
		cmd_byte <= b;
		@(posedge i_core_clk);
		cmd_valid <= 1'b0;
		n = 0;
		while (o_done !== 1'b1 && n < 20000) begin
			@(negedge i_core_clk);
			n++;
		end
		if (n >= 20000) begin
			mismatches++;
			close_out();
		end
	endtask
	task automatic wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (o_busy !== lvl && n < lim) begin
			@(negedge i_core_clk);
			n++;
		end
		if (n >= lim) begin
			mismatches++;
			close_out();
		end
	endtask
	initial begin
		i_resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd_start = 1'b0;
		cmd_stop = 1'b0;
		cmd_read = 1'b0;
		cmd_ack = 1'b0;
		cmd_byte = 8'h00;
		wp = 1'b0;
		mismatches = 0;
		n_compared = 0;
		// wrong type, wrong select, matching write
		row_byte[0] = {~sesw_pkg::DEV_TYPE, SEL, 1'b0};
		row_ack[0] = 1'b0;
		row_byte[1] = {sesw_pkg::DEV_TYPE, ~SEL, 1'b0};
		row_ack[1] = 1'b0;
		row_byte[2] = ADDR_W;
		row_ack[2] = 1'b1;
		repeat (3) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		@(negedge i_core_clk);
		check("idle", {2'h0, o_done, o_cmd_ready, bus.scl, bus.sda, bus.dev_sda_oe_n, o_busy}, 8'h1e);
		for (int i = 0; i < 3; i++) begin
			do_cmd(1'b1, 1'b0, 1'b0, 1'b0, row_byte[i]);
			check("addr ack", {7'h00, o_ack_seen}, {7'h00, row_ack[i]});
		end
		// page write from the last slot, second byte wraps to slot zero
		do_cmd(1'b0, 1'b0, 1'b0, 1'b0, 8'h0f);
		check("waddr ack", {7'h00, o_ack_seen}, 8'h01);
		do_cmd(1'b0, 1'b0, 1'b0, 1'b0, 8'h3c);
		check("data ack", {7'h00, o_ack_seen}, 8'h01);
		do_cmd(1'b0, 1'b1, 1'b0, 1'b0, 8'hc3);
		check("page ack", {7'h00, o_ack_seen}, 8'h01);
		wait_busy(1'b1, 50);
		check("busy", {7'h00, o_busy}, 8'h01);
		// poll while busy must go unanswered
		do_cmd(1'b1, 1'b0, 1'b0, 1'b0, ADDR_W);
		check("poll ack", {7'h00, o_ack_seen}, 8'h00);
		wait_busy(1'b0, P_WR);
		check("busy end", {7'h00, o_busy}, 8'h00);
		@(posedge i_core_clk);
		wp <= 1'b1;
		do_cmd(1'b1, 1'b0, 1'b0, 1'b0, ADDR_W);
		check("after cycle", {7'h00, o_ack_seen}, 8'h01);
		do_cmd(1'b0, 1'b0, 1'b0, 1'b0, 8'h08);
		do_cmd(1'b0, 1'b1, 1'b0, 1'b0, 8'h5a);
		check("prot ack", {7'h00, o_ack_seen}, 8'h01);
		repeat (200) @(negedge i_core_clk);
		check("prot busy", {7'h00, o_busy}, 8'h00);
		@(posedge i_core_clk);
		wp <= 1'b0;
		do_cmd(1'b1, 1'b0, 1'b0, 1'b0, ADDR_W);
		check("ready again", {7'h00, o_ack_seen}, 8'h01);
		do_cmd(1'b0, 1'b0, 1'b0, 1'b0, 8'h08);
		do_cmd(1'b1, 1'b0, 1'b0, 1'b0, ADDR_R);
		check("read ack", {7'h00, o_ack_seen}, 8'h01);
		do_cmd(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
		check("wrapped byte", o_rdata, 8'hc3);
		close_out();
	end
endmodule
`default_nettype wire
